// ### core/cmd_path_consts.vh
// constants for the command path parser: characters, node codes, sizes
`ifndef CMD_PATH_CONSTS_VH
`define CMD_PATH_CONSTS_VH
`define CH_NL        8'h0A
`define CH_CR        8'h0D
`define CH_SPACE     8'h20
`define CH_COLON     8'h3A
`define CH_SEMI      8'h3B
`define CH_QUERY     8'h3F
`define CH_STAR      8'h2A
`define KW_MAX       7
`define NODE_W       4
`define NODE_ROOT    4'h0
`define NODE_INIT    4'h1
`define NODE_MEAS    4'h2
`define NODE_OUTP    4'h3
`define NODE_SOUR    4'h4
`define NODE_STAT    4'h5
`define NODE_SYST    4'h6
`define NODE_VOLT    4'h7
`define NODE_CURR    4'h8
`define NODE_FUNC    4'h9
`define NODE_OPER    4'hA
`define NODE_PRES    4'hB
`define NODE_QUES    4'hC
`define NODE_LEAF    4'hF
`endif

// ### core/cmd_path_parser.v
// character-level command path parser with hierarchical keyword tree
`include "cmd_path_consts.vh"

// What this block does
// - terminator or root colon returns path to root
// - omitted optional keyword acts as if present
// - root accepts six subsystem keywords
// - source children also accepted at root
// - keyword colon descends into matched children
// - status offers operation, preset, questionable
// - after semicolon resolve at previous level
// - leading asterisk means common command
// - trailing question mark makes a query
// - colon after semicolon restarts at root
// - first command starts at root, colon optional
// - line feed ends the program message
// - short form or full long form only; INIT, FUNC, OPER and QUES take the short form only
// - keyword match ignores letter case
// - cr, lf, or pair terminate; second ignored
// - partial long form rejected as error
// - space starts the parameter field
module cmd_path_parser (
    input  wire       clk,          // 10 MHz system clock
    input  wire       reset_n,      // async reset, active low
    input  wire [7:0] rx_data,      // received character
    input  wire       rx_valid,     // character strobe, same clock domain
    output reg        unit_done,    // pulse: message unit resolved
    output reg  [3:0] unit_node,    // node resolved by the unit
    output reg        unit_query,   // unit is a query
    output reg        unit_common,  // unit is a common command
    output reg        unit_has_param, // unit carried a parameter field
    output reg        param_valid,  // pulse: parameter character
    output reg  [7:0] param_data,   // parameter character
    output reg        msg_end,      // pulse: program message ended
    output reg        syntax_error, // pulse: keyword rejected
    output reg  [3:0] path_node     // current tree level
);
    // unit states: collecting a keyword, passing parameter text, discarding after an error
    localparam ST_KEY   = 2'h0;
    localparam ST_PARAM = 2'h1;
    localparam ST_SKIP  = 2'h2;

    // only path_node is seen outside; last_node lives for the whole message, prev_cr for one byte, the rest for one message unit
    reg [1:0]  state;
    reg [55:0] kw;          // upper-cased keyword letters, first char at top
    reg [2:0]  kw_len;
    reg        kw_over;     // keyword longer than any in the tree
    reg [3:0]  last_node;   // last keyword matched in this message
    reg        unit_start;  // no character of the unit taken yet
    reg        prev_cr;     // last byte was a carriage return
    reg        query;
    reg        common;

    // case fold a byte for matching
    wire [7:0] up = (rx_data >= 8'h61 && rx_data <= 8'h7A) ? rx_data - 8'h20 : rx_data;
    wire is_term  = (rx_data == `CH_NL) || (rx_data == `CH_CR);

    // compare collected keyword against short or full long form
    // long length zero: long form does not fit the buffer, short form only
    function fmatch;
        input [55:0] k;
        input [2:0]  n;
        input [31:0] s;
        input [55:0] l;
        input [2:0]  ln;
        begin
            fmatch = ((n == 3'd4) && (k == {24'h000000, s})) ||
                     ((ln != 3'd0) && (n == ln) && (k == l));
        end
    endfunction

    // children of a parent node; SOUR children resolve at root too
    // measure offers only voltage and current; function is a source setting
    function [3:0] lookup;
        input [3:0]  parent;
        input [55:0] k;
        input [2:0]  n;
        begin
            lookup = `NODE_LEAF;
            if (parent == `NODE_ROOT) begin
                // subsystem entry points
                if (fmatch(k, n, "INIT", 56'h0, 3'd0))
                    lookup = `NODE_INIT;
                else if (fmatch(k, n, "MEAS", "MEASURE", 3'd7))
                    lookup = `NODE_MEAS;
                else if (fmatch(k, n, "OUTP", {8'h00, "OUTPUT"}, 3'd6))
                    lookup = `NODE_OUTP;
                else if (fmatch(k, n, "SOUR", {8'h00, "SOURCE"}, 3'd6))
                    lookup = `NODE_SOUR;
                else if (fmatch(k, n, "STAT", {8'h00, "STATUS"}, 3'd6))
                    lookup = `NODE_STAT;
                else if (fmatch(k, n, "SYST", {8'h00, "SYSTEM"}, 3'd6))
                    lookup = `NODE_SYST;
            end
            if (parent == `NODE_ROOT || parent == `NODE_SOUR || parent == `NODE_MEAS) begin
                if (fmatch(k, n, "VOLT", "VOLTAGE", 3'd7))
                    lookup = `NODE_VOLT;
                else if (fmatch(k, n, "CURR", "CURRENT", 3'd7))
                    lookup = `NODE_CURR;
                else if (parent != `NODE_MEAS && fmatch(k, n, "FUNC", 56'h0, 3'd0))
                    lookup = `NODE_FUNC;
            end
            if (parent == `NODE_STAT) begin
                // exactly three children under status
                if (fmatch(k, n, "OPER", 56'h0, 3'd0))
                    lookup = `NODE_OPER;
                else if (fmatch(k, n, "PRES", {8'h00, "PRESET"}, 3'd6))
                    lookup = `NODE_PRES;
                else if (fmatch(k, n, "QUES", 56'h0, 3'd0))
                    lookup = `NODE_QUES;
            end
        end
    endfunction

    // keyword held right-justified, so forms compare against zero-padded strings
    wire [3:0]  hit   = lookup(path_node, kw, kw_len);
    wire        kw_ok = (kw_len != 3'd0) && !kw_over && (hit != `NODE_LEAF);

    // single process; one character per cycle, path held otherwise
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= ST_KEY;  kw <= 56'h0;  kw_len <= 3'd0;  kw_over <= 1'b0;
            last_node <= `NODE_ROOT;  unit_start <= 1'b1;  prev_cr <= 1'b0;
            query <= 1'b0;  common <= 1'b0;  path_node <= `NODE_ROOT;
            unit_done <= 1'b0;  unit_node <= `NODE_ROOT;  unit_query <= 1'b0;
            unit_common <= 1'b0;  unit_has_param <= 1'b0;  param_valid <= 1'b0;
            param_data <= 8'h00;  msg_end <= 1'b0;  syntax_error <= 1'b0;
        end else begin
            // reports last one cycle; path and unit fields hold until changed
            unit_done <= 1'b0;
            param_valid <= 1'b0;
            msg_end <= 1'b0;
            syntax_error <= 1'b0;
            if (rx_valid) begin
                // prev_cr remembers only the byte just before this one
                prev_cr <= (rx_data == `CH_CR);
                // a terminator closes the unit, ends the message, returns to root
                if (is_term) begin
                    // lf right after cr is the pair's second byte: no report, no end
                    if (!(rx_data == `CH_NL && prev_cr)) begin
                        if (state == ST_KEY && kw_len != 3'd0 && !common && !kw_ok)
                            syntax_error <= 1'b1;
                        else if (state != ST_SKIP && !unit_start) begin
                            unit_done <= 1'b1;
                            unit_node <= (state == ST_KEY && kw_ok) ? hit : last_node;
                            unit_query <= query;
                            unit_common <= common;
                            unit_has_param <= (state == ST_PARAM);
                        end
                        msg_end <= 1'b1;
                    end
                    path_node <= `NODE_ROOT;
                    last_node <= `NODE_ROOT;
                    state <= ST_KEY;  kw <= 56'h0;  kw_len <= 3'd0;  kw_over <= 1'b0;
                    unit_start <= 1'b1;  query <= 1'b0;  common <= 1'b0;
                end else if (rx_data == `CH_SEMI) begin
                    // a semicolon closes the unit but leaves the path where it is
                    if (state == ST_KEY && kw_len != 3'd0 && !common && !kw_ok)
                        syntax_error <= 1'b1;
                    else if (state != ST_SKIP && !unit_start) begin
                        unit_done <= 1'b1;
                        unit_node <= (state == ST_KEY && kw_ok) ? hit : last_node;
                        unit_query <= query;
                        unit_common <= common;
                        unit_has_param <= (state == ST_PARAM);
                    end
                    // next unit resolves at the level of the last keyword
                    state <= ST_KEY;  kw <= 56'h0;  kw_len <= 3'd0;  kw_over <= 1'b0;
                    unit_start <= 1'b1;  query <= 1'b0;  common <= 1'b0;
                end else begin
                    // ordinary characters, by unit state
                    case (state)
                        ST_KEY: begin
                            unit_start <= 1'b0;
                            if (rx_data == `CH_STAR && unit_start) begin
                                common <= 1'b1;
                            end else if (rx_data == `CH_COLON && !common) begin
                                if (unit_start) begin
                                    path_node <= `NODE_ROOT;
                                end else if (kw_ok) begin
                                    path_node <= hit;
                                    last_node <= hit;
                                    kw <= 56'h0;  kw_len <= 3'd0;
                                end else begin
                                    syntax_error <= 1'b1;
                                    state <= ST_SKIP;
                                end
                            end else if (rx_data == `CH_QUERY) begin
                                query <= 1'b1;
                            end else if (rx_data == `CH_SPACE) begin
                                if (!unit_start && kw_len != 3'd0 && !common && !kw_ok) begin
                                    syntax_error <= 1'b1;
                                    state <= ST_SKIP;
                                end else if (!unit_start) begin
                                    state <= ST_PARAM;
                                    if (kw_ok)
                                        last_node <= hit;
                                end else begin
                                    unit_start <= 1'b1; // blanks after a separator skipped
                                end
                            end else if (!common) begin
                                // overlong words cannot match; flag stops aliasing
                                if (kw_len == `KW_MAX)
                                    kw_over <= 1'b1;
                                else begin
                                    kw <= {kw[47:0], up};
                                    kw_len <= kw_len + 3'd1;
                                end
                            end
                        end
                        // parameter text passes on raw; its form is checked downstream
                        ST_PARAM: begin
                            param_valid <= 1'b1;
                            param_data <= rx_data;
                        end
                        // after an error all up to the next separator is dropped
                        ST_SKIP: ;
                        default: state <= ST_KEY;
                    endcase
                end
            end
        end
    end
endmodule

// ### verif/host_sender.sv
// host model: sends program message text one character per clock
module host_sender (
    input  wire logic       clk,      // system clock
    output logic      [7:0] rx_data,  // character to the parser
    output logic            rx_valid  // character strobe
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        rx_data  = 8'h00;
        rx_valid = 1'b0;
    end
    // back to back characters; the message text itself carries the terminator
    task send(input string s);
        for (int i = 0; i < s.len(); i++) begin
            @(negedge clk);
            rx_data  = s[i];
            rx_valid = 1'b1;
        end
        @(negedge clk);
        rx_valid = 1'b0;
        rx_data  = ~rx_data;  // idle line no longer shows the last character
    endtask
endmodule

// ### verif/path_parser_props.sv
// checker for the command path parser ports
`include "cmd_path_consts.vh"
module path_parser_props (
    input wire logic       clk,          // system clock
    input wire logic       reset_n,      // async reset, active low
    input wire logic [7:0] rx_data,      // received character
    input wire logic       rx_valid,     // character strobe
    input wire logic       unit_done,    // unit resolved pulse
    input wire logic       unit_common,  // common command flag
    input wire logic       unit_query,   // query flag
    input wire logic       param_valid,  // parameter pulse
    input wire logic [7:0] param_data,   // parameter character
    input wire logic       msg_end,      // message end pulse
    input wire logic       syntax_error, // error pulse
    input wire logic [3:0] path_node     // current tree level
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    wire nl_in = rx_valid && rx_data == `CH_NL;
    wire cr_in = rx_valid && rx_data == `CH_CR;
    // line feed always leaves the path at the top of the tree
    term_root_a: assert property (nl_in |=> path_node == `NODE_ROOT)
        else $error("path not at root after line feed");
    cr_end_a: assert property (cr_in |=> msg_end)
        else $error("carriage return did not end message");
    lf_pair_a: assert property (cr_in ##1 nl_in |=> !msg_end)
        else $error("second terminator byte had an effect");
    end_root_a: assert property (msg_end |-> path_node == `NODE_ROOT)
        else $error("message ended away from root");
    unit_cause_a: assert property (unit_done |-> $past(rx_valid) &&
        $past(rx_data) inside {`CH_SEMI, `CH_NL, `CH_CR})
        else $error("unit resolved without separator");
    param_copy_a: assert property (param_valid |-> $past(rx_valid) &&
        param_data == $past(rx_data))
        else $error("parameter character not passed on");
    idle_hold_a: assert property (!rx_valid |=> !unit_done && !msg_end &&
        !param_valid && !syntax_error && $stable(path_node))
        else $error("activity without a character");
    error_pulse_a: assert property (syntax_error |=> !syntax_error)
        else $error("error pulse longer than one cycle");
    end_cause_a: assert property (msg_end |-> $past(rx_valid) &&
        $past(rx_data) inside {`CH_NL, `CH_CR})
        else $error("message end without a terminator");
    query_cov: cover property (unit_done && unit_query);
    common_cov: cover property (unit_done && unit_common);
    error_cov: cover property (syntax_error);
    param_cov: cover property (param_valid);
endmodule
bind cmd_path_parser path_parser_props u_props (.clk(clk), .reset_n(reset_n),
    .rx_data(rx_data), .rx_valid(rx_valid), .unit_done(unit_done),
    .unit_common(unit_common), .unit_query(unit_query), .param_valid(param_valid),
    .param_data(param_data), .msg_end(msg_end), .syntax_error(syntax_error),
    .path_node(path_node));

// ### verif/tb_scpi_command_path_parser.sv
// self-checking bench for the command path parser
`include "cmd_path_consts.vh"
module tb_scpi_command_path_parser;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    wire  [7:0]  rx_data, param_data;
    wire         rx_valid, unit_done, unit_query, unit_common, unit_has_param;
    wire         param_valid, msg_end, syntax_error;
    wire  [3:0]  unit_node, path_node;
    int          err_count, comparisons, n_units, n_ends, n_errs, n_params, n_hp;
    logic [23:0] units;
    logic [15:0] pchars;                 // last two parameter characters
    logic [23:0] pv_exp = 24'h000000;    // expected units with parameters, then pchars
    always #50 clk = ~clk;
    host_sender host (.clk(clk), .rx_data(rx_data), .rx_valid(rx_valid));
    cmd_path_parser dut (.clk(clk), .reset_n(reset_n), .rx_data(rx_data),
        .rx_valid(rx_valid), .unit_done(unit_done), .unit_node(unit_node),
        .unit_query(unit_query), .unit_common(unit_common),
        .unit_has_param(unit_has_param), .param_valid(param_valid),
        .param_data(param_data), .msg_end(msg_end), .syntax_error(syntax_error),
        .path_node(path_node));
    // record pulses at the falling edge, well clear of the edge that launches them;
    // node of a common command is not decoded, so kept as zero
    always @(negedge clk) begin
        if (unit_done === 1'b1 && n_units < 4) begin
            units[6*n_units +: 6] = {unit_common ? 4'h0 : unit_node, unit_query, unit_common};
        end
        if (param_valid === 1'b1) begin
            pchars = {pchars[7:0], param_data};
        end
        n_units  += (unit_done === 1'b1);
        n_hp     += (unit_done === 1'b1 && unit_has_param === 1'b1);
        n_ends   += (msg_end === 1'b1);
        n_errs   += (syntax_error === 1'b1);
        n_params += (param_valid === 1'b1);
    end
    function logic [5:0] u(input logic [3:0] n, input logic q, input logic c);
        return {n, q, c};
    endfunction
    task chk(input logic [23:0] got, input logic [23:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one message; units discarded by an error never appear in the list
    task run(input string s, input logic [23:0] exp, input int nu, ne, nr, np);
        n_units = 0;
        n_ends = 0;
        n_errs = 0;
        n_params = 0;
        n_hp = 0;
        units = 24'h000000;
        pchars = 16'h0000;
        host.send(s);
        repeat (3) @(negedge clk);
        chk(units, exp);
        chk({n_units[5:0], n_ends[5:0], n_errs[5:0], n_params[5:0]},
            {nu[5:0], ne[5:0], nr[5:0], np[5:0]});
        chk({n_hp[7:0], pchars}, pv_exp);
        chk({20'h00000, path_node}, {20'h00000, `NODE_ROOT});
    endtask
    task t_tree;
        run("STAT:PRES\n", u(`NODE_PRES, 0, 0), 1, 1, 0, 0);
        run("stat:oper?;PRES\n", {u(`NODE_PRES, 0, 0), u(`NODE_OPER, 1, 0)}, 2, 1, 0, 0);
        $display("test tree done");
    endtask
    task t_source;
        pv_exp = {8'h02, "51"};
        run("VOLT 5;CURR 1\n", {u(`NODE_CURR, 0, 0), u(`NODE_VOLT, 0, 0)}, 2, 1, 0, 2);
        pv_exp = 24'h000000;
        run(":SOUR:FUNC\015\n", u(`NODE_FUNC, 0, 0), 1, 1, 0, 0);
        run("SYSTem;:OUTPut\n", {u(`NODE_OUTP, 0, 0), u(`NODE_SYST, 0, 0)}, 2, 1, 0, 0);
        $display("test source done");
    endtask
    task t_root;
        run("MEAS:VOLT?;CURR?\n", {u(`NODE_CURR, 1, 0), u(`NODE_VOLT, 1, 0)}, 2, 1, 0, 0);
        run("STAT:OPER?;:PRES\n", u(`NODE_OPER, 1, 0), 1, 1, 1, 0);
        run("INIT;meas\n", {u(`NODE_MEAS, 0, 0), u(`NODE_INIT, 0, 0)}, 2, 1, 0, 0);
        $display("test root done");
    endtask
    task t_common_form;
        run("*RST;*IDN?\n", {u(4'h0, 1, 1), u(4'h0, 0, 1)}, 2, 1, 0, 0);
        run("outpu\n", 24'h000000, 0, 1, 1, 0);
        $display("test common and forms done");
    endtask
    // a message cut by reset must not leave the path inside a branch
    task t_reset;
        host.send("STAT:OPER");
        repeat (2) @(negedge clk);
        chk({20'h00000, path_node}, {20'h00000, `NODE_STAT});
        reset_n = 1'b0;
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        chk({20'h00000, path_node}, {20'h00000, `NODE_ROOT});
        run("VOLT?\n", u(`NODE_VOLT, 1, 0), 1, 1, 0, 0);
        $display("test reset done");
    endtask
    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(negedge clk);
        reset_n = 1'b1;
        t_tree();
        t_source();
        t_root();
        t_common_form();
        t_reset();
        tally_and_finish();
    end
endmodule
